// ### bench/ssec_far_master.sv
// Far-end camera controller: slave syncs and exposure request.
// Assumes one clock; frames cut to FRAME_L lines to keep runs short.
`timescale 1ns/100ps
module ssec_far_master #(
  parameter int FRAME_L = 3
) (
  input wire logic i_clk,
  input wire logic i_run,
  input wire logic i_expose,
  output ssec_pkg::ssec_sync_t o_sync,
  output logic o_exposure_request
);
  int pix = 100;
  int line = 0;
  initial o_sync = '0;
  initial o_exposure_request = 1'b0;
  always @(posedge i_clk) begin
    if (!i_run) begin
      // Released pins wander, never hold
      pix <= (pix == 100) ? 101 : 100;
      line <= FRAME_L - 1;
      o_sync <= {pix[0], !pix[0]};
    end else begin
      pix <= (pix == ssec_pkg::HSYNC_PERIOD_CLK - 1) ? 0 : pix + 1;
      if (pix == ssec_pkg::HSYNC_PERIOD_CLK - 1) line <= (line + 1) % FRAME_L;
      o_sync.line_sync <= pix < 8;
      o_sync.frame_sync <= line == 0 && pix < 20;
    end
    o_exposure_request <= i_expose;
  end
endmodule : ssec_far_master

// ### bench/ssec_top_sva.sv
// Checker on ssec_top ports: bus answers, sync drivers, streaming.
// Assumes one clock domain; bound to every ssec_top instance.
`timescale 1ns/100ps
module ssec_top_sva #(
  parameter int STRAP_W = 3
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_reset_pin,
  input wire logic i_power_down_pin,
  input wire logic [STRAP_W-1:0] i_strap,
  input wire logic i_exposure_request,
  input wire logic i_frame_sync_pin,
  input wire logic o_line_sync_oe,
  input wire logic o_frame_sync_oe,
  input wire logic o_line_valid,
  input wire logic o_stable,
  input wire logic [ssec_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest
);
  logic [2:0] vs_n;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  // Raw frame syncs since release; saturates
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) vs_n <= 3'h0;
    else if (o_line_sync_oe) vs_n <= 3'h0;
    else if ($rose(i_frame_sync_pin) && vs_n != 3'h7) vs_n <= vs_n + 3'h1;
  end
  chk_oe_pair: assert property (
    o_line_sync_oe == o_frame_sync_oe) else $error("sync enables differ");
  chk_slave_sel: assert property (
    i_avs_write && !o_avs_waitrequest && !i_reset_pin
    && i_avs_address == ssec_pkg::REG_COMMON_I
    && i_avs_writedata[ssec_pkg::COMMON_SLAVE_BIT]
    |-> ##[1:3] !o_line_sync_oe) else $error("slave kept drivers");
  chk_bus_ans: assert property (
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus request not answered");
  chk_unmapped_zero: assert property (
    i_avs_read && !o_avs_waitrequest && i_avs_address > ssec_pkg::REG_STRAP
    |-> o_avs_readdata == 32'h0) else $error("unmapped read not zero");
  chk_pd_quiet: assert property (
    i_power_down_pin [*8] |-> !o_line_valid) else $error("valid in pd");
  chk_hw_reset: assert property (
    i_reset_pin [*8] |-> !o_line_valid && o_line_sync_oe == !i_strap[0])
    else $error("reset pin left state");
  chk_stable_late: assert property (
    !o_line_sync_oe && $rose(o_stable) |-> vs_n >= 3'h2)
    else $error("stable too early");
  chk_valid_idle: assert property (
    $rose(o_line_valid) |-> !i_exposure_request) else $error("early valid");
endmodule : ssec_top_sva
bind ssec_top ssec_top_sva #(.STRAP_W(STRAP_W)) u_ssec_top_sva (
  .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_reset_pin(i_reset_pin),
  .i_power_down_pin(i_power_down_pin), .i_strap(i_strap),
  .i_exposure_request(i_exposure_request),
  .i_frame_sync_pin(i_frame_sync_pin), .o_line_sync_oe(o_line_sync_oe),
  .o_frame_sync_oe(o_frame_sync_oe), .o_line_valid(o_line_valid),
  .o_stable(o_stable), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest));

// ### bench/ssec_top_test.sv
// Bench for ssec_top: bus tasks, far-end master, random settings.
// Assumes the bus answers one cycle after a request is seen.
`timescale 1ns/100ps
module ssec_top_test;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic rst_pin = 1'b0;
  logic pd_pin = 1'b0;
  logic [2:0] strap = 3'h0;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, rv;
  logic wreq, ls_o, ls_oe, fs_o, fs_oe, lval, stable, req;
  logic run = 1'b0;
  logic expose = 1'b0;
  logic ls_q = 1'b0;
  logic fs_q = 1'b0;
  ssec_pkg::ssec_sync_t far;
  int fails = 0;
  int tests_run = 0;
  int ln = 0;
  int vs = 0;
  int div, e0;
  longint t0;
  wire ls_w = ls_oe ? ls_o : far.line_sync;
  wire fs_w = fs_oe ? fs_o : far.frame_sync;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    ls_q <= ls_w;
    fs_q <= fs_w;
    if (ls_w && !ls_q) ln <= ln + 1;
    if (fs_w && !fs_q) vs <= vs + 1;
  end
  ssec_top u_ssec_top (.i_sys_clk(clk), .i_rstn(rstn),
    .i_reset_pin(rst_pin), .i_power_down_pin(pd_pin), .i_strap(strap),
    .i_exposure_request(req), .i_line_sync_pin(ls_w),
    .i_frame_sync_pin(fs_w), .o_line_sync_pin(ls_o), .o_line_sync_oe(ls_oe),
    .o_frame_sync_pin(fs_o), .o_frame_sync_oe(fs_oe), .o_line_valid(lval),
    .o_stable(stable), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq));
  ssec_far_master u_ssec_far_master (.i_clk(clk), .i_run(run),
    .i_expose(expose), .o_sync(far), .o_exposure_request(req));
  function automatic int pre_clk(input int d);
    return ssec_pkg::PRECHARGE_LINES * ssec_pkg::PRECHARGE_MULT
      * ssec_pkg::PIX_PER_SYSCLK * (d + 1);
  endfunction : pre_clk
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [3:0] a, input int d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    rd <= !w;
    wr <= w;
    wdata <= 32'(d);
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    rv = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wreq !== 1'b0) fails++;
  endtask : bus
  task automatic poll(input logic [2:0] st, input int lim);
    for (int n = 0; n < lim && rv[2:0] !== st; n++)
      bus(1'b0, ssec_pkg::REG_STATUS, 0);
    if (rv[2:0] !== st) fails++;
  endtask : poll
  task automatic final_report;
    $display("tests_run %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  initial begin
    rv = $urandom(32'hba50);
    strap = 3'(($urandom % 4) * 2);
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    for (int a = 0; a < 6; a++) begin
      bus(1'b0, (a < 5) ? 4'(a) : 4'(5 + $urandom % 11), 0);
      if (a != 3) check(rv, (a == 2) ? 32'h4 : (a == 4) ? 32'(strap) : 0);
    end
    check(32'(ls_oe), 32'h1);
    $display("test defaults done");
    bus(1'b1, ssec_pkg::REG_CONTROL, 8);
    expose <= 1'b1;
    repeat (1500) @(posedge clk);
    bus(1'b0, ssec_pkg::REG_STATUS, 0);
    check(32'(rv[2:0]), 32'(ssec_pkg::EXP_IDLE));
    expose <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      div = i ? $urandom % 4 : 0;
      bus(1'b1, ssec_pkg::REG_CLKDIV, div);
      bus(1'b0, ssec_pkg::REG_CLKDIV, 0);
      check(rv, 32'(div));
      bus(1'b1, ssec_pkg::REG_CONTROL, 12);
      t0 = $time;
      expose <= 1'b1;
      poll(3'(ssec_pkg::EXP_PRECHARGE), 400 * (div + 1));
      check(32'(($time - t0) / 10 < 472 * (div + 1) + 20), 1);
      t0 = $time;
      poll(3'(ssec_pkg::EXP_INTEGRATE), 1200 * (div + 1));
      e0 = pre_clk(div) - int'(($time - t0) / 10);
      check(32'(e0 > -7 && e0 < 7), 1);
      repeat (472 * (1 + $urandom % 3)) @(posedge clk);
      bus(1'b0, ssec_pkg::REG_STATUS, 0);
      check(32'(rv[2:0]), 32'(ssec_pkg::EXP_INTEGRATE));
      expose <= 1'b0;
      repeat (2) @(posedge clk);
      e0 = ln;
      for (int n = 0; n < 6000 * (div + 1) && lval !== 1'b1; n++)
        @(posedge clk);
      check(32'((ln - e0) inside {8, 9}), 1);
      rst_pin <= 1'b1;
      repeat (10) @(posedge clk);
      rst_pin <= 1'b0;
      repeat (4) @(posedge clk);
      bus(1'b0, ssec_pkg::REG_CONTROL, 0);
      check(rv, 32'(ssec_pkg::CONTROL_RST));
      $display("test exposure %0d done", i);
    end
    bus(1'b1, ssec_pkg::REG_CLKDIV, 42);
    bus(1'b1, ssec_pkg::REG_CONTROL, 1);
    bus(1'b1, ssec_pkg::REG_CONTROL, 0);
    bus(1'b0, ssec_pkg::REG_CLKDIV, 0);
    check(rv, 32'(ssec_pkg::CLKDIV_RST));
    div = $urandom % 64;
    bus(1'b1, ssec_pkg::REG_CLKDIV, div);
    pd_pin <= 1'b1;
    repeat (12) @(posedge clk);
    pd_pin <= 1'b0;
    repeat (4) @(posedge clk);
    bus(1'b0, ssec_pkg::REG_CLKDIV, 0);
    check(rv, 32'(div));
    $display("test resets done");
    run <= 1'b1;
    bus(1'b1, ssec_pkg::REG_COMMON_I, 32'h40);
    repeat (3) @(posedge clk);
    check(32'({ls_oe, fs_oe, stable}), 0);
    e0 = vs;
    for (int n = 0; n < 7000 && stable !== 1'b1; n++) @(posedge clk);
    check(32'(vs - e0), 2);
    $display("test slave done");
    final_report();
  end
  initial begin
    #1000000;
    fails++;
    final_report();
  end
endmodule : ssec_top_test

// ### design/ssec_top.sv
// Sync, frame-exposure, reset and power-down control of an image sensor.
// Assumes sync pins arrive asynchronously; Avalon master honours wait.
//
// Summary of operation
// R1: Master by default; common control bit 6 set selects slave sync; here strap bit 0 high makes slave the default.
// R2: In slave mode the master supplies clock and high line sync.
// R3: In slave mode the master drives high frame sync pulses.
// R4: Slave mode releases line and frame sync output drivers.
// R5: Line sync sampled by clock; frame sync sampled on line sync edges.
// R6: Master holds line sync high above six clocks.
// R7: Lines every 472 clocks, frames every 625 lines.
// R8: Frame sync longer than line sync, shorter than 472 clocks.
// R9: Output flagged stable only from the second frame sync onward; in master mode stable is set at once unless halted or reset.
// R10: Frame exposure accepted only in progressive scan.
// R11: Request high precharges the array then integrates while held.
// R12: Precharge lasts 292 times 4 pixel periods, scaled by divider.
// R13: Pixel period scales with the six-bit clock divider field.
// R14: Master holds request beyond precharge plus sync uncertainty.
// R15: Request is synchronised to the line sync rising edge.
// R16: Request falling starts line-by-line frame streaming.
// R17: Eight non-valid lines precede valid lines marked by line valid.
// R18: Reset pin high resets everything to defaults.
// R19: A software command also resets the device.
// R20: Power-down pin halts activity, resets all but bus registers.
// R21: Software power-down suspends activity; clock keeps running here.
// R22: Strap pins sampled at power-up select register defaults.
// R23: Every programmable register is reachable over the bus.
//
// Local design decisions: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module ssec_top #(
  parameter int STRAP_W = 3
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_reset_pin,
  input wire logic i_power_down_pin,
  input wire logic [STRAP_W-1:0] i_strap,
  input wire logic i_exposure_request,
  input wire logic i_line_sync_pin,
  input wire logic i_frame_sync_pin,
  output logic o_line_sync_pin,
  output logic o_line_sync_oe,
  output logic o_frame_sync_pin,
  output logic o_frame_sync_oe,
  output logic o_line_valid,
  output logic o_stable,
  input wire logic [ssec_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest
);
  ssec_pkg::ssec_av_req_t req;
  logic [7:0] common_i;
  logic [5:0] clkdiv;
  logic [7:0] control;
  logic [STRAP_W-1:0] strap;
  logic strap_taken;
  logic [ssec_pkg::SYNC_STAGES-1:0] ls_sync, fs_sync, fx_sync, rp_sync;
  logic [ssec_pkg::SYNC_STAGES-1:0] pd_sync;
  ssec_pkg::ssec_sync_t pin_q;
  logic ls_q_d;
  logic fs_line;
  logic fs_line_d;
  logic [1:0] vs_count;
  logic [9:0] hcnt;
  logic [9:0] vcnt;
  logic int_line, int_frame;
  ssec_pkg::ssec_exp_state_t st;
  logic [17:0] pre_cnt;
  logic [3:0] dummy_cnt;
  logic [9:0] line_cnt;
  logic [9:0] hpos;
  logic line_pulse;
  logic soft_rst, halt, slave, exposure_request_ok;
  logic ack;

  function automatic logic [17:0] precharge_clks(input logic [5:0] div);
    precharge_clks = 18'(ssec_pkg::PRECHARGE_LINES * ssec_pkg::PRECHARGE_MULT
      * ssec_pkg::PIX_PER_SYSCLK * (int'(div) + 1));
  endfunction : precharge_clks

  assign req = '{i_avs_address, i_avs_read, i_avs_write, i_avs_writedata};
  // R1 slave select
  assign slave = common_i[ssec_pkg::COMMON_SLAVE_BIT];
  // R19 soft reset
  assign soft_rst = control[ssec_pkg::CTRL_SOFT_RESET_BIT] | rp_sync[1];
  // R21 clock kept running
  assign halt = pd_sync[1] | control[ssec_pkg::CTRL_SOFT_POWER_DOWN_PIN_BIT];
  // R10 progressive only
  assign exposure_request_ok = control[ssec_pkg::CTRL_PROGRESSIVE_BIT]
    & control[ssec_pkg::CTRL_EXPOSURE_REQUEST_EN_BIT];

  // Two-stage synchronisers for all pins but the straps
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ls_sync <= '0;
      fs_sync <= '0;
      fx_sync <= '0;
      rp_sync <= '0;
      pd_sync <= '0;
    end else begin
      ls_sync <= {ls_sync[0], i_line_sync_pin};
      fs_sync <= {fs_sync[0], i_frame_sync_pin};
      fx_sync <= {fx_sync[0], i_exposure_request};
      rp_sync <= {rp_sync[0], i_reset_pin};
      pd_sync <= {pd_sync[0], i_power_down_pin};
    end
  end

  // Bus slave: one wait cycle, then acknowledge
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ack <= 1'b0;
      o_avs_waitrequest <= 1'b1;
    end else begin
      ack <= (req.read | req.write) & ~ack;
      o_avs_waitrequest <= ~((req.read | req.write) & ~ack);
    end
  end

  // R22 strap capture after release
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      strap <= '0;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      strap <= i_strap;
      strap_taken <= 1'b1;
    end
  end

  // R23 register writes
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      common_i <= ssec_pkg::COMMON_I_RST;
      clkdiv <= ssec_pkg::CLKDIV_RST;
      control <= ssec_pkg::CONTROL_RST;
    end else if (rp_sync[1] || control[ssec_pkg::CTRL_SOFT_RESET_BIT]) begin
      // R18 defaults reloaded
      common_i <= ssec_pkg::COMMON_I_RST;
      // R22 strap default kept
      common_i[ssec_pkg::COMMON_SLAVE_BIT] <= strap[0];
      clkdiv <= ssec_pkg::CLKDIV_RST;
      control <= ssec_pkg::CONTROL_RST;
    end else if (!strap_taken) begin
      // R22 strap selects slave default
      common_i[ssec_pkg::COMMON_SLAVE_BIT] <= i_strap[0];
    end else if (req.write && ack) begin
      unique case (req.address)
        ssec_pkg::REG_COMMON_I: common_i <= req.writedata[7:0];
        ssec_pkg::REG_CLKDIV: clkdiv <= req.writedata[5:0];
        ssec_pkg::REG_CONTROL: control <= req.writedata[7:0];
        default: ;
      endcase
    end
  end

  // Read data
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_avs_readdata <= '0;
    end else if (req.read && !ack) begin
      unique case (req.address)
        ssec_pkg::REG_COMMON_I: o_avs_readdata <= {24'h0, common_i};
        ssec_pkg::REG_CLKDIV: o_avs_readdata <= {26'h0, clkdiv};
        ssec_pkg::REG_CONTROL: o_avs_readdata <= {24'h0, control};
        ssec_pkg::REG_STATUS: o_avs_readdata <= {26'h0, o_stable,
          o_line_valid, 1'b0, 3'(st)};
        ssec_pkg::REG_STRAP: o_avs_readdata <= 32'(strap);
        default: o_avs_readdata <= '0;
      endcase
    end
  end

  // Internal master timing
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hcnt <= '0;
      vcnt <= '0;
    end else if (halt || soft_rst) begin
      // R20 power-down clears timing
      hcnt <= '0;
      vcnt <= '0;
    end else if (hcnt == 10'(ssec_pkg::HSYNC_PERIOD_CLK - 1)) begin
      hcnt <= '0;
      vcnt <= (vcnt == 10'(ssec_pkg::FRAME_LINES - 1)) ? '0 : vcnt + 10'h1;
    end else begin
      hcnt <= hcnt + 10'h1;
    end
  end
  assign int_line = (hcnt < 10'h20);
  assign int_frame = (vcnt == 10'h0) && (hcnt < 10'h40);

  // R4 drivers off in slave
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_line_sync_oe <= 1'b1;
      o_frame_sync_oe <= 1'b1;
      o_line_sync_pin <= 1'b0;
      o_frame_sync_pin <= 1'b0;
    end else begin
      o_line_sync_oe <= ~slave;
      o_frame_sync_oe <= ~slave;
      o_line_sync_pin <= ~slave & int_line & ~halt;
      o_frame_sync_pin <= ~slave & int_frame & ~halt;
    end
  end

  // R5 frame sync sampled on line edge
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_q <= '0;
      ls_q_d <= 1'b0;
      fs_line <= 1'b0;
      fs_line_d <= 1'b0;
    end else begin
      pin_q <= '{ls_sync[1], fs_sync[1]};
      ls_q_d <= pin_q.line_sync;
      // Stale master capture would hide the first external frame
      if (!slave) begin
        fs_line <= 1'b0;
      end else if (pin_q.line_sync && !ls_q_d) begin
        fs_line <= pin_q.frame_sync;
      end
      fs_line_d <= fs_line;
    end
  end

  assign line_pulse = slave ? (pin_q.line_sync & ~ls_q_d)
    : (hcnt == 10'h0);

  // R9 stable from second frame sync in slave; at once in master
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      vs_count <= '0;
      o_stable <= 1'b0;
    end else if (halt || soft_rst || !slave) begin
      vs_count <= '0;
      o_stable <= ~slave & ~halt & ~soft_rst;
    end else begin
      if (fs_line && !fs_line_d
        && vs_count != 2'(ssec_pkg::STABLE_VSYNCS)) begin
        vs_count <= vs_count + 2'h1;
      end
      // Dropped on entry to slave until two frames are seen
      o_stable <= (vs_count == 2'(ssec_pkg::STABLE_VSYNCS));
    end
  end

  // Exposure sequencer
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st <= ssec_pkg::EXP_IDLE;
      pre_cnt <= '0;
      dummy_cnt <= '0;
      line_cnt <= '0;
    end else if (halt || soft_rst) begin
      st <= ssec_pkg::EXP_IDLE;
      pre_cnt <= '0;
      dummy_cnt <= '0;
      line_cnt <= '0;
    end else begin
      unique case (st)
        ssec_pkg::EXP_IDLE: begin
          // R10 progressive gate
          if (exposure_request_ok && fx_sync[1]) begin
            st <= ssec_pkg::EXP_WAIT_LINE;
          end
        end
        ssec_pkg::EXP_WAIT_LINE: begin
          // R15 start on line edge
          if (!fx_sync[1]) begin
            st <= ssec_pkg::EXP_IDLE;
          end else if (line_pulse) begin
            st <= ssec_pkg::EXP_PRECHARGE;
            // R12 R13 divider-scaled time
            pre_cnt <= precharge_clks(clkdiv);
          end
        end
        ssec_pkg::EXP_PRECHARGE: begin
          // R11 precharge then integrate
          if (pre_cnt <= 18'h1) begin
            st <= ssec_pkg::EXP_INTEGRATE;
          end
          pre_cnt <= pre_cnt - 18'h1;
        end
        ssec_pkg::EXP_INTEGRATE: begin
          // R16 fall starts readout
          if (!fx_sync[1]) begin
            st <= ssec_pkg::EXP_DUMMY;
            dummy_cnt <= '0;
          end
        end
        ssec_pkg::EXP_DUMMY: begin
          // R17 eight non-valid lines
          if (line_pulse) begin
            if (dummy_cnt == 4'(ssec_pkg::DUMMY_LINES - 1)) begin
              st <= ssec_pkg::EXP_STREAM;
              line_cnt <= '0;
            end
            dummy_cnt <= dummy_cnt + 4'h1;
          end
        end
        ssec_pkg::EXP_STREAM: begin
          if (line_pulse) begin
            if (line_cnt == 10'(ssec_pkg::PRECHARGE_LINES - 1)) begin
              st <= ssec_pkg::EXP_IDLE;
            end
            line_cnt <= line_cnt + 10'h1;
          end
        end
        default: st <= ssec_pkg::EXP_IDLE;
      endcase
    end
  end

  // R17 line valid marking
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hpos <= '0;
      o_line_valid <= 1'b0;
    end else begin
      hpos <= line_pulse ? '0 : hpos + 10'h1;
      o_line_valid <= (st == ssec_pkg::EXP_STREAM) && !line_pulse
        && (hpos < 10'h160);
    end
  end
endmodule : ssec_top

// ### shared/ssec_pkg.sv
// Shared constants and carriers for the sensor sync and exposure control.
// Assumes one 100 MHz system clock; registers reached over Avalon-MM.
package ssec_pkg;
  localparam int ADDR_W = 4;
  // Word-index register offsets (byte address = 4 * index)
  localparam logic [ADDR_W-1:0] REG_COMMON_I = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CLKDIV = 4'h1;
  localparam logic [ADDR_W-1:0] REG_CONTROL = 4'h2;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h3;
  localparam logic [ADDR_W-1:0] REG_STRAP = 4'h4;
  // Field positions
  localparam int COMMON_SLAVE_BIT = 6;
  localparam int CTRL_SOFT_RESET_BIT = 0;
  localparam int CTRL_SOFT_POWER_DOWN_PIN_BIT = 1;
  localparam int CTRL_PROGRESSIVE_BIT = 2;
  localparam int CTRL_EXPOSURE_REQUEST_EN_BIT = 3;
  // Reset values
  localparam logic [7:0] COMMON_I_RST = 8'h00;
  localparam logic [5:0] CLKDIV_RST = 6'h00;
  localparam logic [7:0] CONTROL_RST = 8'h04;
  // Timing figures
  localparam int PRECHARGE_LINES = 292;
  localparam int PRECHARGE_MULT = 4;
  localparam int PIX_PER_SYSCLK = 2;
  localparam int HSYNC_PERIOD_CLK = 472;
  localparam int FRAME_LINES = 625;
  localparam int DUMMY_LINES = 8;
  localparam int STABLE_VSYNCS = 2;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [2:0] {
    EXP_IDLE, EXP_WAIT_LINE, EXP_PRECHARGE, EXP_INTEGRATE, EXP_DUMMY,
    EXP_STREAM
  } ssec_exp_state_t;

  typedef struct packed {
    logic line_sync;
    logic frame_sync;
  } ssec_sync_t;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } ssec_av_req_t;
endpackage : ssec_pkg
